// >>> hw/lcfr_pkg.sv
package lcfr_pkg;

    // ========================================================
    // Register map
    localparam logic [16:0] ORIENT_ADDR  = 17'h1fffb;
    localparam logic [16:0] DISPCTL_ADDR = 17'h1fffc;
    localparam logic [16:0] YRES_ADDR    = 17'h1fffd;
    localparam logic [16:0] FILLVAL_ADDR = 17'h1fffe;
    localparam logic [16:0] FILLCMD_ADDR = 17'h1ffff;

    // ========================================================
    // Field positions
    localparam int ORIENT_VSEL_BIT = 2;
    localparam int ORIENT_HSEL_BIT = 1;
    localparam int ORIENT_BL_BIT   = 0;
    localparam int DISP_OFF_BIT    = 7;
    localparam int BLINK_TWO_BIT   = 6;
    localparam int BLINK_ONE_BIT   = 5;
    localparam int BUSY_BIT        = 0;

    // ========================================================
    // Reset values and command codes
    localparam logic       VSEL_RST     = 1'b1;
    localparam logic       HSEL_RST     = 1'b0;
    localparam logic       BL_RST       = 1'b1;
    localparam logic [7:0] FILLVAL_RST  = 8'h00;
    localparam logic       DISPLAY_OFF_RST     = 1'b0;
    localparam logic       BLINK_RST    = 1'b0;
    localparam logic       BUSY_RST     = 1'b0;
    localparam logic [7:0] CONV_RST     = 8'h00;
    localparam logic [7:0] FILL_GO_CODE = 8'h01;

    // ========================================================
    // Frame buffer geometry and timing
    localparam logic [8:0] COL_LAST      = 9'h1ff;
    localparam logic [7:0] ROW_LAST      = 8'hef;
    localparam int         CLK_HZ        = 40_000_000;
    localparam int         BOOT_US       = 100;
    localparam int         BOOT_CYCLES   = (BOOT_US * (CLK_HZ / 1_000_000));
    localparam int         BLINK_FRAMES  = 32;

    // ========================================================
    // Types
    typedef enum logic [1:0] {
        LCFR_ORIENT_VMIRROR,
        LCFR_ORIENT_ROT180,
        LCFR_ORIENT_NORMAL,
        LCFR_ORIENT_HMIRROR
    } lcfr_orient_t;

    typedef struct packed {
        logic [1:0] attr;
        logic [1:0] red;
        logic [1:0] green;
        logic [1:0] blue;
    } lcfr_pixel_t;

    typedef struct packed {
        logic        we;
        logic [16:0] addr;
        lcfr_pixel_t data;
    } lcfr_fb_wr_t;

endpackage : lcfr_pkg

// >>> hw/lcfr_regs.sv
`timescale 1ns/1ps
// What this block does
// - Orientation register is write-only; vertical 1, horizontal 0, backlight 1 at reset.
// - Vertical/horizontal select pick normal, horizontal mirror, 180 rotation or vertical mirror.
// - Backlight enable output is the inverse of the backlight bit.
// - Display-off bit forces panel pixel data to zero; resets to zero.
// - Bits 5 and 6 enable blink groups one and two; both reset to zero.
// - Low five bits of display control writes are ignored.
// - Reading display control address returns the latest X conversion result.
// - Conversion results from touch controller are stored automatically, readable anytime.
// - Next address reads latest Y conversion result; writes there do nothing.
// - Fill value is write-only pixel-format byte, resets to zero.
// - Writing 0x01 to fill command fills the whole frame buffer.
// - Busy bit reads 1 from fill acceptance until fill ends; resets to 0.
// - After reset release and configuration load, a fill starts automatically.
// - Fill covers 512 columns by 240 lines at stride 0x200.
// - Pixel byte is attribute, red, green, blue, two bits each.
// - Attribute 10/11 join blink groups one/two, only when enabled.
module lcfr_regs (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rstn,
    // Host register port
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [16:0]        reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic      [7:0]         reg_rdata,
    // Conversion results from the touch controller
    input  wire logic               conv_x_valid,
    input  wire logic               conv_y_valid,
    input  wire logic [7:0]         conv_data,
    // Frame buffer write port used by the fill engine
    output lcfr_pkg::lcfr_fb_wr_t   fb_wr,
    // Pixel scan-out path
    input  wire logic               frame_start,
    input  wire lcfr_pkg::lcfr_pixel_t pix_in,
    output lcfr_pkg::lcfr_pixel_t   pix_out,
    // Panel controls
    output lcfr_pkg::lcfr_orient_t  orient,
    output logic                    backlight_enable_out,
    output logic                    fill_busy
);

    // ========================================================
    // Host writes
    logic        vsel_q, hsel_q, bl_q;
    logic        display_off_q, blink_one_enable_q, blink_two_enable_q;
    logic [7:0]  fill_value_q;
    logic [7:0]  x_res_q, y_res_q;
    logic        busy_q;
    logic [8:0]  col_q;
    logic [7:0]  row_q;
    logic [13:0] boot_cnt_q;
    logic        boot_done_q;
    logic [5:0]  frame_cnt_q;
    logic        blink_phase_q;
    logic        wr_orient, wr_disp, wr_fval, fill_go, boot_go, fill_last;

    always_comb begin
        wr_orient = reg_wr && (reg_addr == lcfr_pkg::ORIENT_ADDR);
        wr_disp   = reg_wr && (reg_addr == lcfr_pkg::DISPCTL_ADDR);
        wr_fval   = reg_wr && (reg_addr == lcfr_pkg::FILLVAL_ADDR);
        // Command accepted only with the exact code and while idle
        fill_go   = reg_wr && (reg_addr == lcfr_pkg::FILLCMD_ADDR)
                    && (reg_wdata == lcfr_pkg::FILL_GO_CODE) && !busy_q;
        fill_last = (col_q == lcfr_pkg::COL_LAST) && (row_q == lcfr_pkg::ROW_LAST);
    end

    // Orientation and backlight register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            vsel_q <= lcfr_pkg::VSEL_RST;
            hsel_q <= lcfr_pkg::HSEL_RST;
            bl_q   <= lcfr_pkg::BL_RST;
        end else if (wr_orient) begin
            vsel_q <= reg_wdata[lcfr_pkg::ORIENT_VSEL_BIT];
            hsel_q <= reg_wdata[lcfr_pkg::ORIENT_HSEL_BIT];
            bl_q   <= reg_wdata[lcfr_pkg::ORIENT_BL_BIT];
        end
    end

    // Display control; low five bits are dropped on purpose
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            display_off_q      <= lcfr_pkg::DISPLAY_OFF_RST;
            blink_one_enable_q <= lcfr_pkg::BLINK_RST;
            blink_two_enable_q <= lcfr_pkg::BLINK_RST;
        end else if (wr_disp) begin
            display_off_q      <= reg_wdata[lcfr_pkg::DISP_OFF_BIT];
            blink_one_enable_q <= reg_wdata[lcfr_pkg::BLINK_ONE_BIT];
            blink_two_enable_q <= reg_wdata[lcfr_pkg::BLINK_TWO_BIT];
        end
    end

    // Fill value register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fill_value_q <= lcfr_pkg::FILLVAL_RST;
        end else if (wr_fval) begin
            fill_value_q <= reg_wdata;
        end
    end

    // ========================================================
    // Conversion results; host writes never touch them
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            x_res_q <= lcfr_pkg::CONV_RST;
            y_res_q <= lcfr_pkg::CONV_RST;
        end else begin
            if (conv_x_valid) begin
                x_res_q <= conv_data;
            end
            if (conv_y_valid) begin
                y_res_q <= conv_data;
            end
        end
    end

    // Read mux; write-only locations read as zero
    // Reads have no side effects, so polling busy costs the host nothing
    always_comb begin
        reg_rdata = 8'h00;
        if (!reg_rd) begin
            reg_rdata = 8'h00;
        end else if (reg_addr == lcfr_pkg::DISPCTL_ADDR) begin
            reg_rdata = x_res_q;
        end else if (reg_addr == lcfr_pkg::YRES_ADDR) begin
            reg_rdata = y_res_q;
        end else if (reg_addr == lcfr_pkg::FILLCMD_ADDR) begin
            reg_rdata = {7'h00, busy_q};
        end
    end

    // ========================================================
    // Boot delay stands in for the flash-to-SRAM configuration load
    // A host fill issued during the delay absorbs the automatic one
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boot_cnt_q  <= 14'h0000;
            boot_done_q <= 1'b0;
        end else if (!boot_done_q) begin
            if (boot_cnt_q == 14'(lcfr_pkg::BOOT_CYCLES - 1)) begin
                boot_done_q <= 1'b1;
            end
            boot_cnt_q <= boot_cnt_q + 14'h0001;
        end
    end

    assign boot_go = !boot_done_q && (boot_cnt_q == 14'(lcfr_pkg::BOOT_CYCLES - 1));

    // Fill engine: one pixel per clock over the full 512 x 240 space
    // A full pass takes 122880 clocks, about 3 ms, well inside the host's wait
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_q <= lcfr_pkg::BUSY_RST;
            col_q  <= 9'h000;
            row_q  <= 8'h00;
        end else if (!busy_q) begin
            if (fill_go || boot_go) begin
                busy_q <= 1'b1;
                col_q  <= 9'h000;
                row_q  <= 8'h00;
            end
        end else if (fill_last) begin
            busy_q <= 1'b0;
        end else if (col_q == lcfr_pkg::COL_LAST) begin
            col_q <= 9'h000;
            row_q <= row_q + 8'h01;
        end else begin
            col_q <= col_q + 9'h001;
        end
    end

    // Write strobe registered with the address; line stride is 0x200
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fb_wr <= '0;
        end else begin
            fb_wr.we   <= busy_q;
            fb_wr.addr <= {row_q, col_q};
            fb_wr.data <= fill_value_q;
        end
    end

    // ========================================================
    // Blink phase toggles every few frames
    // Limitation: the blink rate follows the frame rate, not a fixed time
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_cnt_q   <= 6'h00;
            blink_phase_q <= 1'b0;
        end else if (frame_start) begin
            if (frame_cnt_q == 6'(lcfr_pkg::BLINK_FRAMES - 1)) begin
                frame_cnt_q   <= 6'h00;
                blink_phase_q <= !blink_phase_q;
            end else begin
                frame_cnt_q <= frame_cnt_q + 6'h01;
            end
        end
    end

    // Pixel output; blanking beats blink, blink beats colour
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pix_out <= '0;
        end else if (display_off_q) begin
            pix_out <= '0;
        end else if (blink_phase_q && ((pix_in.attr == 2'b10 && blink_one_enable_q)
                     || (pix_in.attr == 2'b11 && blink_two_enable_q))) begin
            pix_out <= '0;
        end else begin
            pix_out <= pix_in;
        end
    end

    // Panel control outputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            orient               <= lcfr_pkg::LCFR_ORIENT_NORMAL;
            backlight_enable_out <= 1'b0;
        end else begin
            orient               <= lcfr_pkg::lcfr_orient_t'({vsel_q, hsel_q});
            backlight_enable_out <= !bl_q;
        end
    end

    assign fill_busy = busy_q;

    // ========================================================
    // Checks
    a_fill_cmd_start: assert property (@(posedge clk) disable iff (!rstn)
        fill_go |=> busy_q)
        else $error("fill command did not raise busy");
    a_fill_ignore_busy: assert property (@(posedge clk) disable iff (!rstn)
        busy_q && !fill_last |=> busy_q && $stable(row_q) || col_q != 9'h000 || row_q != 8'h00)
        else $error("fill restarted while busy");
    a_busy_ends: assert property (@(posedge clk) disable iff (!rstn)
        busy_q && fill_last |=> !busy_q)
        else $error("busy did not clear at fill end");
    a_backlight_inv: assert property (@(posedge clk) disable iff (!rstn)
        wr_orient ##2 1 |-> backlight_enable_out == !$past(reg_wdata[0], 2))
        else $error("backlight output not inverted");
    a_blank_pixels: assert property (@(posedge clk) disable iff (!rstn)
        display_off_q |=> pix_out == '0)
        else $error("pixels not blanked");
    a_xread: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr == lcfr_pkg::DISPCTL_ADDR |-> reg_rdata == x_res_q)
        else $error("x result not returned");
    a_fb_write: assert property (@(posedge clk) disable iff (!rstn)
        busy_q |=> fb_wr.we && fb_wr.addr == {$past(row_q), $past(col_q)})
        else $error("fill write address wrong");
    a_boot_fill: assert property (@(posedge clk) disable iff (!rstn)
        boot_go |=> busy_q)
        else $error("automatic fill did not start");

    // ========================================================
    // Control register checks
    a_orient_map: assert property (@(posedge clk) disable iff (!rstn)
        wr_orient ##2 1 |-> orient == lcfr_pkg::lcfr_orient_t'(
            {$past(reg_wdata[lcfr_pkg::ORIENT_VSEL_BIT], 2),
             $past(reg_wdata[lcfr_pkg::ORIENT_HSEL_BIT], 2)}))
        else $error("orientation does not follow select bits");
    a_disp_write: assert property (@(posedge clk) disable iff (!rstn)
        wr_disp |=> display_off_q == $past(reg_wdata[lcfr_pkg::DISP_OFF_BIT])
            && blink_one_enable_q == $past(reg_wdata[lcfr_pkg::BLINK_ONE_BIT])
            && blink_two_enable_q == $past(reg_wdata[lcfr_pkg::BLINK_TWO_BIT]))
        else $error("display control write lost");
    a_disp_hold: assert property (@(posedge clk) disable iff (!rstn)
        !wr_disp |=> $stable({display_off_q, blink_one_enable_q, blink_two_enable_q}))
        else $error("display control changed without a write");
    a_fval_hold: assert property (@(posedge clk) disable iff (!rstn)
        !wr_fval |=> $stable(fill_value_q))
        else $error("fill value changed without a write");

    // ========================================================
    // Conversion result and busy bit read checks
    a_x_store: assert property (@(posedge clk) disable iff (!rstn)
        conv_x_valid |=> x_res_q == $past(conv_data))
        else $error("x result not stored");
    a_y_store: assert property (@(posedge clk) disable iff (!rstn)
        conv_y_valid |=> y_res_q == $past(conv_data))
        else $error("y result not stored");
    a_yread: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr == lcfr_pkg::YRES_ADDR |-> reg_rdata == y_res_q)
        else $error("y result not returned");
    a_busy_read: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr == lcfr_pkg::FILLCMD_ADDR |-> reg_rdata[lcfr_pkg::BUSY_BIT] == busy_q)
        else $error("busy bit not returned");

    // ========================================================
    // Fill and scan-out checks
    a_bad_code: assert property (@(posedge clk) disable iff (!rstn)
        reg_wr && reg_addr == lcfr_pkg::FILLCMD_ADDR && reg_wdata != lcfr_pkg::FILL_GO_CODE
            && !busy_q && !boot_go |=> !busy_q)
        else $error("fill started on a wrong code");
    a_fill_data: assert property (@(posedge clk) disable iff (!rstn)
        busy_q |=> fb_wr.data == $past(fill_value_q))
        else $error("fill data differs from fill value");
    a_blink_off: assert property (@(posedge clk) disable iff (!rstn)
        !display_off_q && blink_phase_q && blink_one_enable_q && pix_in.attr == 2'b10
            |=> pix_out == '0)
        else $error("blink group one not blacked out");
    a_pix_pass: assert property (@(posedge clk) disable iff (!rstn)
        !display_off_q && !pix_in.attr[1] |=> pix_out == $past(pix_in))
        else $error("plain pixel altered");

endmodule : lcfr_regs

// >>> sim/lcfr_host.sv
`timescale 1ns/1ps
// ========================================================
// Host processor model on the parallel register port
module lcfr_host (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [16:0]      reg_addr,
    output logic [7:0]       reg_wdata,
    input  wire logic [7:0]  reg_rdata
);
    int slow = 0;  // Idle cycles before each access, a sluggish host

    // Bus idle at time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = '0;
        reg_wdata = '0;
    end

    // Frame buffer is never touched here, only the register port is driven
    task automatic wr(logic [16:0] a, logic [7:0] d);
        repeat (slow + 1) @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d;  // Released data must not look valid
    endtask : wr

    // Read data is taken at the edge that ends the access
    task automatic rd(logic [16:0] a, output logic [7:0] d);
        repeat (slow + 1) @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        d = reg_rdata;
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
    endtask : rd
endmodule : lcfr_host

// >>> sim/test_lcd_ctrl_fill_regs.sv
`timescale 1ns/1ps
// ========================================================
// Self-checking bench for the register bank and fill engine
module test_lcd_ctrl_fill_regs;
    logic                   clk, rstn, conv_x_valid, conv_y_valid, frame_start;
    logic                   reg_wr, reg_rd, backlight_enable_out, fill_busy;
    logic [16:0]            reg_addr;
    logic [7:0]             reg_wdata, reg_rdata, conv_data, rd_v, x_v, y_v, fv, s1;
    lcfr_pkg::lcfr_pixel_t  pix_in, pix_out;
    lcfr_pkg::lcfr_fb_wr_t  fb_wr;
    lcfr_pkg::lcfr_orient_t orient;
    logic [15:0]            lfsr = 16'h3f19;
    int                     miscompares = 0, n_compared = 0, n;

    lcfr_regs dut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .conv_x_valid(conv_x_valid), .conv_y_valid(conv_y_valid), .conv_data(conv_data),
        .fb_wr(fb_wr), .frame_start(frame_start), .pix_in(pix_in), .pix_out(pix_out),
        .orient(orient), .backlight_enable_out(backlight_enable_out), .fill_busy(fill_busy));
    lcfr_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Repeatable random bytes
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction : rnd

    // Expected orientation from vertical and horizontal selects
    function automatic lcfr_pkg::lcfr_orient_t exp_orient(logic [1:0] vh);
        case (vh)
            2'b10: return lcfr_pkg::LCFR_ORIENT_NORMAL;
            2'b11: return lcfr_pkg::LCFR_ORIENT_HMIRROR;
            2'b01: return lcfr_pkg::LCFR_ORIENT_ROT180;
            default: return lcfr_pkg::LCFR_ORIENT_VMIRROR;
        endcase
    endfunction : exp_orient

    // Frame buffer address of the i-th filled pixel, 512 per line
    function automatic logic [16:0] exp_addr(int i);
        return 17'((i / 512) * 17'h200 + (i % 512));
    endfunction : exp_addr

    task automatic chk(string what, logic [16:0] exp, logic [16:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
    endtask : do_reset

    // Scan-out pixel is registered, so look one cycle after launch
    task automatic pix(logic [7:0] p, output logic [7:0] q);
        @(posedge clk);
        pix_in <= p;
        @(posedge clk);
        @(negedge clk);
        q = pix_out;
    endtask : pix

    task automatic frames(int cnt);
        repeat (cnt) begin
            @(posedge clk);
            frame_start <= 1'b1;
            @(posedge clk);
            frame_start <= 1'b0;
        end
    endtask : frames

    // Follow the fill engine's writes from the first pixel
    task automatic fill_watch(logic [7:0] v, int cnt);
        n = 0;
        while (fb_wr.we !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        for (int i = 0; i < cnt; i++) begin
            chk("fb we", 17'h1, fb_wr.we);
            chk("fb addr", exp_addr(i), fb_wr.addr);
            chk("fb data", v, fb_wr.data);
            @(negedge clk);
        end
    endtask : fill_watch

    // Watchdog: the whole run needs well under 20000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        final_report();
    end

    // Main sequence; everything before the boot fill fits in its 4000 cycle delay
    initial begin
        {rstn, conv_x_valid, conv_y_valid, frame_start} = '0;
        conv_data = '0;
        pix_in    = '0;
        do_reset();
        @(negedge clk);
        chk("orient rst", lcfr_pkg::LCFR_ORIENT_NORMAL, orient);
        chk("backlight rst", 17'h0, backlight_enable_out);
        chk("busy rst", 17'h0, fill_busy);
        for (int i = 0; i < 8; i++) begin
            fv      = rnd();
            fv[2:0] = i[2:0];
            host.wr(lcfr_pkg::ORIENT_ADDR, fv);
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("orient", exp_orient(fv[2:1]), orient);
            chk("backlight", 17'(!fv[0]), backlight_enable_out);
        end
        $display("orientation test done");
        // Results arrive from the touch controller while the host is slow
        host.slow = 2;
        x_v = rnd();
        y_v = rnd();
        @(posedge clk);
        conv_x_valid <= 1'b1;
        conv_data    <= x_v;
        @(posedge clk);
        conv_x_valid <= 1'b0;
        conv_y_valid <= 1'b1;
        conv_data    <= y_v;
        @(posedge clk);
        conv_y_valid <= 1'b0;
        conv_data    <= ~y_v;
        host.wr(lcfr_pkg::YRES_ADDR, rnd());
        host.wr(lcfr_pkg::DISPCTL_ADDR, 8'h1f);
        host.rd(lcfr_pkg::DISPCTL_ADDR, rd_v);
        chk("x result", x_v, rd_v);
        host.rd(lcfr_pkg::YRES_ADDR, rd_v);
        chk("y result", y_v, rd_v);
        host.rd(lcfr_pkg::FILLVAL_ADDR, rd_v);
        chk("write-only read", 17'h0, rd_v);
        host.rd(17'h00100, rd_v);
        chk("unmapped read", 17'h0, rd_v);
        host.slow = 0;
        $display("conversion test done");
        // Pixel path: low control bits ignored, display off blacks out
        fv = rnd();
        pix(fv, rd_v);
        chk("pix on", fv, rd_v);
        host.wr(lcfr_pkg::DISPCTL_ADDR, 8'h80 | (rnd() & 8'h1f));
        pix(rnd() | 8'h01, rd_v);
        chk("pix off", 17'h0, rd_v);
        // Each blink group alternates colour and black across 32 frames
        for (int g = 1; g < 3; g++) begin
            host.wr(lcfr_pkg::DISPCTL_ADDR, g == 1 ? 8'h20 : 8'h40);
            fv = rnd() | 8'h01; // Nonzero colour, so the black phase is visible
            fv[7:6] = g == 1 ? 2'b10 : 2'b11;
            frames(32);
            pix(fv, s1);
            frames(32);
            pix(fv, rd_v);
            chk("blink toggles", 17'h1, 17'((s1 == 8'h00) ^ (rd_v == 8'h00)));
        end
        $display("pixel path test done");
        // Fill: other codes ignored, 0x01 fills, repeat while busy does not restart
        host.wr(lcfr_pkg::FILLCMD_ADDR, rnd() | 8'h02);
        @(negedge clk);
        chk("busy ignored", 17'h0, fill_busy);
        fv = rnd();
        host.wr(lcfr_pkg::FILLVAL_ADDR, fv);
        host.wr(lcfr_pkg::FILLCMD_ADDR, 8'h01);
        @(negedge clk);
        chk("busy", 17'h1, fill_busy);
        fill_watch(fv, 600);
        host.wr(lcfr_pkg::FILLCMD_ADDR, 8'h01);
        @(negedge clk);
        chk("no restart", 17'h1, 17'(fb_wr.addr > 17'd600));
        host.rd(lcfr_pkg::FILLCMD_ADDR, rd_v);
        chk("busy bit", 17'h1, rd_v & 8'h01);
        $display("fill test done");
        // Boot fill after a fresh reset uses the cleared fill value
        do_reset();
        n = 0;
        while (n < 5000) begin
            @(posedge clk);
            n++;
            #1;
            if (fill_busy === 1'b1) break;
        end
        chk("boot fill edges", 17'(lcfr_pkg::BOOT_CYCLES), 17'(n));
        fill_watch(8'h00, 20);
        $display("boot fill test done");
        final_report();
    end
endmodule : test_lcd_ctrl_fill_regs
